// *** htc_pkg.sv ***
// Package for the homing and trigger control block
package htc_pkg;

  localparam int unsigned CLK_HZ    = 50_000_000;
  localparam int unsigned TICK_US   = 1000;
  localparam int unsigned TICK_CYC  = CLK_HZ / 1_000_000 * TICK_US;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_FBADDR = 8'h04;
  localparam logic [7:0] OFF_TRIG   = 8'h08;
  localparam logic [7:0] OFF_WARN   = 8'h0C;
  localparam logic [7:0] OFF_HOFS   = 8'h10;
  localparam logic [7:0] OFF_PLIM   = 8'h14;
  localparam logic [7:0] OFF_NLIM   = 8'h18;
  localparam logic [7:0] OFF_SPEED  = 8'h1C;
  localparam logic [7:0] OFF_STAT   = 8'h20;
  localparam logic [7:0] OFF_CAPT   = 8'h24;
  localparam logic [7:0] OFF_POS    = 8'h28;
  localparam logic [7:0] OFF_CMD    = 8'h2C;
  localparam logic [7:0] OFF_JOGOFS = 8'h30;
  localparam logic [7:0] OFF_FSEL   = 8'h34;

  // Feedback address word fields
  localparam int unsigned FB_SWCAP  = 16;
  localparam int unsigned FB_TORQUE = 17;

  // Trigger edge select fields
  localparam int unsigned TE_FLAG_FALL = 0;
  localparam int unsigned TE_IDX_FALL  = 1;
  localparam int unsigned TE_USE_FLAG  = 2;
  localparam int unsigned TE_USE_IDX   = 3;

  // Control register fields
  localparam int unsigned CT_START  = 0;
  localparam int unsigned CT_JOG    = 1;
  localparam int unsigned CT_ABORT  = 2;
  localparam int unsigned CT_PROG   = 3;

  // Status register fields
  localparam int unsigned ST_HOME   = 0;
  localparam int unsigned ST_SRCH   = 1;
  localparam int unsigned ST_DVZ    = 2;
  localparam int unsigned ST_WARN   = 3;
  localparam int unsigned ST_BUSY   = 4;
  localparam int unsigned ST_TRIGMV = 5;
  localparam int unsigned ST_SLIMEN = 6;

  localparam logic [31:0] FBADDR_RST = 32'h0000_0720;
  localparam logic [31:0] FSEL_RST   = 32'h0000_C000;

  typedef enum logic [1:0] {HTC_FLAG_HOME, HTC_FLAG_PLIM, HTC_FLAG_NLIM,
                            HTC_FLAG_FAULT} htc_flag_t;

  typedef struct packed {
    logic home;
    logic plim;
    logic nlim;
    logic fault;
    logic index;
  } htc_inputs_t;

  typedef struct packed {
    logic home_complete;
    logic search_busy;
    logic vel_zero;
    logic warn_fe;
  } htc_status_t;

endpackage

// *** htc_top.sv ***
// Homing search and trigger capture control for one motor axis
// Behaviour
// (R1) Edge select picks flag, index, or both
// (R2) Flag choice selects one of four flags
// (R3) Host disables protective input used as flag
// (R4) Feedback word bit17 selects torque triggering
// (R5) Bit16 selects software position capture
// (R6) Low sixteen bits hold feedback address
// (R7) Torque trigger is warning error status true
// (R8) Move relative to captured trigger position
// (R9) Warning already true fires trigger at once
// (R10) Home switch level qualifies index pulse
// (R11) New zero from capture plus home offset
// (R12) Soft limits off during search, on after
// (R13) Plan stop at new zero, end at home
// (R14) On-line start gives no completion flag
// (R15) Home complete clears at reset and start
// (R16) Search bit is inverse of home complete; here it is the search state, so both can be low, or both high in a jog
// (R17) Monitor waits for velocity zero too
// (R18) Program start holds until move ends
// (R19) Listed homings start and end together
// (R20) On-line uses addressed motor, buffered own
// (R21) Logic program names motor in each command
// (R22) Error after trigger keeps home position
// (R23) Speed sign sets direction, magnitude speed
// (R24) Capture freezes on first event per arm
// (R25) Warning compare runs every servo cycle
module htc_top
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        HOME_SWITCH_INPUT,
  input  wire logic        POSITIVE_LIMIT_INPUT,
  input  wire logic        NEGATIVE_LIMIT_INPUT,
  input  wire logic        AMPLIFIER_FAULT_INPUT,
  input  wire logic        INDEX_INPUT,
  input  wire logic [31:0] ENCODER_COUNT,
  input  wire logic [31:0] SOFTWARE_POSITION,
  input  wire logic        MOVE_ERROR,
  output logic      [31:0] COMMANDED_POSITION,
  output logic             HOME_COMPLETE,
  output logic             SEARCH_IN_PROGRESS,
  output logic             VELOCITY_ZERO,
  output logic             SOFT_LIMITS_ENABLED,
  output logic             PROGRAM_HOLD,
  output logic             LIMIT_PROTECT_OFF,
  output logic             FAULT_PROTECT_OFF
);

  typedef enum logic [1:0] {HTC_IDLE, HTC_SEARCH, HTC_STOP} htc_state_t;

  logic               rst_meta_reg;
  logic               rst_sync_reg;
  logic               rst_n;
  htc_state_t         state_reg;
  logic        [31:0] fbaddr_reg;
  logic        [3:0]  edge_sel_reg;
  logic        [1:0]  flag_choice_reg;
  logic        [31:0] fsel_reg;
  logic        [31:0] warn_thr_reg;
  logic        [31:0] home_ofs_reg;
  logic        [31:0] plim_reg;
  logic        [31:0] nlim_reg;
  logic        [31:0] speed_reg;
  logic        [31:0] jog_ofs_reg;
  logic        [31:0] capt_reg;
  logic        [31:0] zero_reg;
  logic        [31:0] target_reg;
  logic        [31:0] cmd_pos_reg;
  logic               jog_mode_reg;
  logic               home_reg;
  logic               armed_reg;
  logic               warn_reg;
  logic               trigmv_reg;
  logic               prog_reg;
  logic               slim_en_reg;
  logic               flag_prev_reg;
  logic               idx_prev_reg;
  logic        [15:0] tick_reg;
  logic               tick;
  logic               flag_lvl;
  logic               flag_evt;
  logic               idx_evt;
  logic               hw_evt;
  logic               trig;
  logic               apb_wr;
  logic               apb_rd;
  logic               start_cmd;
  logic        [31:0] fe;
  logic        [31:0] fe_abs;
  logic        [31:0] step;
  logic        [31:0] trig_pos;
  logic        [31:0] rd_next;
  logic               addr_ok;
  logic               abort_cmd;
  logic               search_next;

  function automatic logic edge_hit(input logic now, input logic prev,
                                    input logic fall);
    edge_hit = fall ? (prev & ~now) : (~prev & now);
  endfunction

  function automatic logic [31:0] abs32(input logic [31:0] v);
    abs32 = v[31] ? 32'(-v) : v;
  endfunction

  assign rst_n = rst_sync_reg;

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign apb_wr    = PSEL & PENABLE & PWRITE & PREADY;
  assign apb_rd    = PSEL & ~PENABLE & ~PWRITE;
  assign start_cmd = apb_wr && PADDR == htc_pkg::OFF_CTRL &&
                     PWDATA[htc_pkg::CT_START]; // [R20]

  // Millisecond tick for the homing speed in counts per millisecond
  assign tick = (tick_reg == 16'(htc_pkg::TICK_CYC - 1));

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      tick_reg <= 16'h0000;
    else if (tick)
      tick_reg <= 16'h0000;
    else
      tick_reg <= tick_reg + 16'h0001;
  end

  // Chosen capture flag
  always_comb
  begin
    unique case (htc_pkg::htc_flag_t'(flag_choice_reg))
      htc_pkg::HTC_FLAG_HOME:  flag_lvl = HOME_SWITCH_INPUT;    // [R2]
      htc_pkg::HTC_FLAG_PLIM:  flag_lvl = POSITIVE_LIMIT_INPUT; // [R2]
      htc_pkg::HTC_FLAG_NLIM:  flag_lvl = NEGATIVE_LIMIT_INPUT; // [R2]
      htc_pkg::HTC_FLAG_FAULT: flag_lvl = AMPLIFIER_FAULT_INPUT; // [R2]
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_prev_reg <= 1'b0;
      idx_prev_reg  <= 1'b0;
    end
    else
    begin
      flag_prev_reg <= flag_lvl;
      idx_prev_reg  <= INDEX_INPUT;
    end
  end

  assign flag_evt = edge_hit(flag_lvl, flag_prev_reg,
                             edge_sel_reg[htc_pkg::TE_FLAG_FALL]);
  assign idx_evt  = edge_hit(INDEX_INPUT, idx_prev_reg,
                             edge_sel_reg[htc_pkg::TE_IDX_FALL]);

  // Dual mode: the selected index edge captures only while the flag is at its active level
  always_comb
  begin
    unique case (edge_sel_reg[htc_pkg::TE_USE_IDX:htc_pkg::TE_USE_FLAG])
      2'b01:   hw_evt = flag_evt;                                  // [R1]
      2'b10:   hw_evt = idx_evt;                                   // [R1]
      2'b11:   hw_evt = idx_evt & (flag_lvl ^
                        edge_sel_reg[htc_pkg::TE_FLAG_FALL]);      // [R10]
      default: hw_evt = 1'b0;
    endcase
  end

  // Following error checked each cycle against the sixteenth-count threshold
  assign fe     = cmd_pos_reg - (fbaddr_reg[htc_pkg::FB_SWCAP] ?
                  SOFTWARE_POSITION : ENCODER_COUNT);
  assign fe_abs = abs32(fe);

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      warn_reg <= 1'b0;
    else
      warn_reg <= (|fe_abs[31:28]) ||                  // [R25]
                  {fe_abs[27:0], 4'h0} > warn_thr_reg; // [R7]
  end

  // Torque mode fires on the warning level, so a move starting with it
  // set triggers on the first search cycle
  assign trig = armed_reg && state_reg == HTC_SEARCH &&
                (fbaddr_reg[htc_pkg::FB_TORQUE] ? warn_reg    // [R4] [R9]
                                                : hw_evt);    // [R24]

  assign trig_pos = fbaddr_reg[htc_pkg::FB_SWCAP] ? SOFTWARE_POSITION
                                                   : ENCODER_COUNT; // [R5]
  assign step = speed_reg[31] ? 32'(-abs32(speed_reg)) : speed_reg; // [R23]

  // Next-state view, so the limit flag moves with the search output
  assign abort_cmd   = MOVE_ERROR ||
                       (!start_cmd && apb_wr && PADDR == htc_pkg::OFF_CTRL &&
                        PWDATA[htc_pkg::CT_ABORT]);
  assign search_next = (state_reg == HTC_IDLE && start_cmd) ||
                       (state_reg == HTC_SEARCH && !abort_cmd && !trig);

  // Axis state machine
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg    <= HTC_IDLE;
      armed_reg    <= 1'b0;
      jog_mode_reg <= 1'b0;
      trigmv_reg   <= 1'b0;
      capt_reg     <= 32'h0000_0000;
      target_reg   <= 32'h0000_0000;
      cmd_pos_reg  <= 32'h0000_0000;
      zero_reg     <= 32'h0000_0000;
    end
    else
    begin
      unique case (state_reg)
        HTC_IDLE:
        begin
          if (start_cmd)
          begin
            state_reg    <= HTC_SEARCH;                     // [R14]
            armed_reg    <= 1'b1;
            jog_mode_reg <= PWDATA[htc_pkg::CT_JOG];
            trigmv_reg   <= 1'b1;
          end
        end
        HTC_SEARCH:
        begin
          if (abort_cmd)
          begin
            state_reg <= HTC_IDLE;
            armed_reg <= 1'b0;
          end
          else if (trig)
          begin
            armed_reg <= 1'b0;                              // [R24]
            capt_reg  <= trig_pos;                          // [R8]
            if (jog_mode_reg)
              target_reg <= trig_pos + jog_ofs_reg;         // [R8]
            else
            begin
              // New zero: capture plus offset in sixteenth-counts
              zero_reg   <= trig_pos +
                            {{4{home_ofs_reg[31]}}, home_ofs_reg[31:4]}; // [R11]
              target_reg <= trig_pos +
                            {{4{home_ofs_reg[31]}}, home_ofs_reg[31:4]};
            end
            state_reg <= HTC_STOP;                          // [R13]
          end
          else if (tick)
            cmd_pos_reg <= cmd_pos_reg + step;              // [R23]
        end
        HTC_STOP:
        begin
          // Error after trigger leaves zero untouched
          if (MOVE_ERROR)
            state_reg <= HTC_IDLE;                          // [R22]
          else if (cmd_pos_reg == target_reg)
          begin
            state_reg  <= HTC_IDLE;                         // [R13]
            trigmv_reg <= 1'b0;
          end
          else if (tick)
          begin
            // Step toward the target by the speed magnitude, reversing if needed
            if ($signed(target_reg - cmd_pos_reg) > $signed(abs32(step)))
              cmd_pos_reg <= cmd_pos_reg + abs32(step);
            else if ($signed(cmd_pos_reg - target_reg) >
                     $signed(abs32(step)))
              cmd_pos_reg <= cmd_pos_reg - abs32(step);
            else
              cmd_pos_reg <= target_reg;                    // [R13]
          end
        end
        default:
          state_reg <= HTC_IDLE;
      endcase
    end
  end

  // Home complete: cleared at a non-jog start, set at a non-jog trigger before motion ends
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      home_reg <= 1'b0;                                     // [R15]
    else if (trig && !jog_mode_reg)
      home_reg <= 1'b1;                                     // [R15]
    else if (state_reg == HTC_IDLE && start_cmd && !PWDATA[htc_pkg::CT_JOG])
      home_reg <= 1'b0;                                     // [R15]
  end

  // Soft limits are on only with a non-zero limit and outside a search
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      slim_en_reg <= 1'b0;
    else
      slim_en_reg <= (plim_reg != 32'h0000_0000 || nlim_reg != 32'h0000_0000)
                     && !search_next;                        // [R12]
  end

  // Program hold covers a move started with the program bit set, until it ends
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      prog_reg <= 1'b0;
    else if (state_reg == HTC_IDLE && start_cmd)
      prog_reg <= PWDATA[htc_pkg::CT_PROG];                 // [R18] [R19]
    else if (state_reg == HTC_IDLE)
      prog_reg <= 1'b0;                                     // [R18]
  end

  // Registers written by software
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fbaddr_reg      <= htc_pkg::FBADDR_RST;
      edge_sel_reg    <= 4'h0;
      flag_choice_reg <= 2'h0;
      fsel_reg        <= htc_pkg::FSEL_RST;
      warn_thr_reg    <= 32'h0000_0000;
      home_ofs_reg    <= 32'h0000_0000;
      plim_reg        <= 32'h0000_0000;
      nlim_reg        <= 32'h0000_0000;
      speed_reg       <= 32'h0000_0000;
      jog_ofs_reg     <= 32'h0000_0000;
    end
    else if (apb_wr)
    begin
      unique case (PADDR)
        htc_pkg::OFF_FBADDR: fbaddr_reg <= {14'h0000, PWDATA[17:0]}; // [R6]
        htc_pkg::OFF_TRIG:
        begin
          edge_sel_reg    <= PWDATA[3:0];                   // [R1]
          flag_choice_reg <= PWDATA[9:8];                   // [R2]
        end
        htc_pkg::OFF_FSEL:   fsel_reg     <= PWDATA;
        htc_pkg::OFF_WARN:   warn_thr_reg <= PWDATA;
        htc_pkg::OFF_HOFS:   home_ofs_reg <= PWDATA;
        htc_pkg::OFF_PLIM:   plim_reg     <= PWDATA;
        htc_pkg::OFF_NLIM:   nlim_reg     <= PWDATA;
        htc_pkg::OFF_SPEED:  speed_reg    <= PWDATA;
        htc_pkg::OFF_JOGOFS: jog_ofs_reg  <= PWDATA;
        default:             fbaddr_reg   <= fbaddr_reg;
      endcase
    end
  end

  always_comb
  begin
    addr_ok = 1'b1;
    unique case (PADDR)
      htc_pkg::OFF_CTRL:   rd_next = 32'h0000_0000;
      htc_pkg::OFF_FBADDR: rd_next = fbaddr_reg;
      htc_pkg::OFF_TRIG:   rd_next = {22'h0, flag_choice_reg, 4'h0,
                                      edge_sel_reg};
      htc_pkg::OFF_WARN:   rd_next = warn_thr_reg;
      htc_pkg::OFF_HOFS:   rd_next = home_ofs_reg;
      htc_pkg::OFF_PLIM:   rd_next = plim_reg;
      htc_pkg::OFF_NLIM:   rd_next = nlim_reg;
      htc_pkg::OFF_SPEED:  rd_next = speed_reg;
      htc_pkg::OFF_STAT:   rd_next = {25'h0, slim_en_reg, trigmv_reg,
                                      state_reg != HTC_IDLE, warn_reg,
                                      state_reg == HTC_IDLE,
                                      state_reg == HTC_SEARCH, home_reg};
      htc_pkg::OFF_CAPT:   rd_next = capt_reg;
      htc_pkg::OFF_POS:    rd_next = cmd_pos_reg - zero_reg;    // [R11]
      htc_pkg::OFF_CMD:    rd_next = cmd_pos_reg;
      htc_pkg::OFF_JOGOFS: rd_next = jog_ofs_reg;
      htc_pkg::OFF_FSEL:   rd_next = fsel_reg;
      default:
      begin
        rd_next = 32'h0000_0000;
        addr_ok = 1'b0;
      end
    endcase
  end

  // Answer one cycle after setup: read data is latched during setup
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~addr_ok;
      if (apb_rd)
        PRDATA <= rd_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      COMMANDED_POSITION  <= 32'h0000_0000;
      HOME_COMPLETE       <= 1'b0;
      SEARCH_IN_PROGRESS  <= 1'b0;
      VELOCITY_ZERO       <= 1'b1;
      SOFT_LIMITS_ENABLED <= 1'b0;
      PROGRAM_HOLD        <= 1'b0;
      LIMIT_PROTECT_OFF   <= 1'b0;
      FAULT_PROTECT_OFF   <= 1'b0;
    end
    else
    begin
      COMMANDED_POSITION  <= cmd_pos_reg;
      HOME_COMPLETE       <= home_reg;
      SEARCH_IN_PROGRESS  <= state_reg == HTC_SEARCH;       // [R16]
      VELOCITY_ZERO       <= state_reg == HTC_IDLE;
      SOFT_LIMITS_ENABLED <= slim_en_reg;
      PROGRAM_HOLD        <= prog_reg;                      // [R18]
      LIMIT_PROTECT_OFF   <= fsel_reg[17];
      FAULT_PROTECT_OFF   <= fsel_reg[18];
    end
  end

endmodule

// *** htc_monitor.sv ***
// Checker of homing status and register side effects at the block ports
module htc_monitor
(
  input wire logic        CLK_SYS,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        HOME_COMPLETE,
  input wire logic        SEARCH_IN_PROGRESS,
  input wire logic        VELOCITY_ZERO,
  input wire logic        SOFT_LIMITS_ENABLED,
  input wire logic        PROGRAM_HOLD,
  input wire logic        LIMIT_PROTECT_OFF
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic wr = PSEL && PENABLE && PREADY && PWRITE;
  wire logic start_wr = wr && PADDR == htc_pkg::OFF_CTRL && PWDATA[0];
  wire logic fsel_wr = wr && PADDR == htc_pkg::OFF_FSEL;
  // Jog moves leave home complete alone, so the inverse check skips them
  logic jog_reg;
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      jog_reg <= 1'b0;
    else if (start_wr && VELOCITY_ZERO)
      jog_reg <= PWDATA[htc_pkg::CT_JOG];
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  property p_inverse;
    SEARCH_IN_PROGRESS && !jog_reg |-> !HOME_COMPLETE;
  endproperty
  a_inverse: assert property (p_inverse)
    else $error("search and home complete both high");
  property p_found;
    $rose(HOME_COMPLETE) |-> $past(SEARCH_IN_PROGRESS);
  endproperty
  a_found: assert property (p_found)
    else $error("home complete rose outside a search");
  property p_moving;
    $rose(HOME_COMPLETE) |-> !VELOCITY_ZERO;
  endproperty
  a_moving: assert property (p_moving)
    else $error("home complete rose after the stop");
  property p_limits_off;
    SEARCH_IN_PROGRESS |-> !SOFT_LIMITS_ENABLED;
  endproperty
  a_limits_off: assert property (p_limits_off)
    else $error("soft limits active during search");
  property p_protect;
    fsel_wr |=> ##1 LIMIT_PROTECT_OFF == $past(PWDATA[17], 2);
  endproperty
  a_protect: assert property (p_protect)
    else $error("limit protection output does not follow selector");
  property p_keep;
    $fell(HOME_COMPLETE) |-> $past(start_wr) || $past(start_wr, 2)
      || $past(start_wr, 3);
  endproperty
  a_keep: assert property (p_keep)
    else $error("home complete dropped without a start");
  property p_start;
    start_wr && VELOCITY_ZERO |-> ##[1:3] SEARCH_IN_PROGRESS;
  endproperty
  a_start: assert property (p_start)
    else $error("search did not begin after start");
  property p_hold;
    $fell(PROGRAM_HOLD) |-> VELOCITY_ZERO;
  endproperty
  a_hold: assert property (p_hold)
    else $error("program hold released while moving");

  c_home: cover property ($rose(HOME_COMPLETE));
  c_hold: cover property ($fell(PROGRAM_HOLD));
  c_protect: cover property (LIMIT_PROTECT_OFF);
endmodule

// *** htc_axis_model.sv ***
// Axis plant model feeding encoder and software position back to the block
module htc_axis_model
(
  input  wire logic        clk,
  input  wire logic [31:0] cmd_pos,
  input  wire logic [31:0] lag,
  output logic      [31:0] enc_count,
  output logic      [31:0] sw_pos
);
  timeunit 1ns;
  timeprecision 1ps;
  // Software reading trails by lag so a following error can be staged
  always_ff @(posedge clk)
  begin
    enc_count <= cmd_pos;
    sw_pos    <= cmd_pos - lag;
  end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the homing and trigger control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  flg = 4'h0;
  logic        idx = 1'b0;
  logic        move_err = 1'b0;
  logic [31:0] lag = 32'h0;
  logic [31:0] prdata, enc, swpos, cmdpos, q, snap;
  logic        pready, pslverr, slverr;
  logic        home, srch, vz, slim, hold, lpo, fpo;
  wire  [3:0]  st = {hold, vz, srch, home};
  int          mismatches = 0;
  int          checks_done = 0;

  always #10 clk_sys = ~clk_sys;

  htc_top u_htc_top
  (
    .CLK_SYS(clk_sys), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .HOME_SWITCH_INPUT(flg[0]),
    .POSITIVE_LIMIT_INPUT(flg[1]), .NEGATIVE_LIMIT_INPUT(flg[2]),
    .AMPLIFIER_FAULT_INPUT(flg[3]), .INDEX_INPUT(idx),
    .ENCODER_COUNT(enc), .SOFTWARE_POSITION(swpos), .MOVE_ERROR(move_err),
    .COMMANDED_POSITION(cmdpos), .HOME_COMPLETE(home),
    .SEARCH_IN_PROGRESS(srch), .VELOCITY_ZERO(vz),
    .SOFT_LIMITS_ENABLED(slim), .PROGRAM_HOLD(hold),
    .LIMIT_PROTECT_OFF(lpo), .FAULT_PROTECT_OFF(fpo)
  );

  htc_axis_model u_htc_axis_model
  (
    .clk(clk_sys), .cmd_pos(cmdpos), .lag(lag), .enc_count(enc),
    .sw_pos(swpos)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_on(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (st[b] !== v && n < lim)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (st[b] !== v)
    begin
      mismatches++;
      $display("MISMATCH status bit %0d expected %b", b, v);
      final_report();
    end
  endtask

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      mismatches++;
      $display("MISMATCH pready expected 1 seen %b", pready);
      final_report();
    end
    q = prdata;
    slverr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Error stop after the trigger; home must survive it
  task automatic stop_move();
    move_err <= 1'b1;
    @(posedge clk_sys);
    wait_on(2, 1'b1, 100);
    move_err <= 1'b0;
    flg <= 4'h0;
    chk("home kept", 32'h1, {31'h0, home});
  endtask

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, htc_pkg::OFF_FBADDR, 32'h0);
    chk("fbaddr", htc_pkg::FBADDR_RST, q);
    apb(1'b0, htc_pkg::OFF_STAT, 32'h0);
    chk("stat", 32'h0000_0004, q & 32'h0000_003F);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, slverr});
    apb(1'b1, htc_pkg::OFF_FBADDR, 32'h0003_0720);
    apb(1'b0, htc_pkg::OFF_FBADDR, 32'h0);
    chk("fbaddr modes", 32'h0003_0720, q);
    apb(1'b1, htc_pkg::OFF_FBADDR, htc_pkg::FBADDR_RST);
    apb(1'b1, htc_pkg::OFF_FSEL, 32'h0006_C000);
    repeat (2) @(posedge clk_sys);
    chk("protect off", 32'h3, {30'h0, fpo, lpo});
    apb(1'b1, htc_pkg::OFF_PLIM, 32'h0000_03E8);
    apb(1'b1, htc_pkg::OFF_NLIM, 32'hFFFF_FC18);
    apb(1'b1, htc_pkg::OFF_SPEED, 32'h0000_0064);
    apb(1'b1, htc_pkg::OFF_HOFS, 32'h0000_0020);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, htc_pkg::OFF_TRIG, {22'h0, i[1:0], 8'h04});
      apb(1'b1, htc_pkg::OFF_CTRL, 32'h1);
      wait_on(1, 1'b1, 10);
      chk("home cleared", 32'h0, {31'h0, home});
      chk("limits off", 32'h0, {31'h0, slim});
      flg[(i + 1) % 4] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("other flag", 32'h1, {31'h0, srch});
      snap = enc;
      flg[i] <= 1'b1;
      wait_on(0, 1'b1, 10);
      chk("search ends", 32'h0, {31'h0, srch});
      apb(1'b0, htc_pkg::OFF_CAPT, 32'h0);
      chk("capture", snap, q);
      stop_move();
    end
    lag <= 32'h5;
    apb(1'b1, htc_pkg::OFF_WARN, 32'h0000_0020);
    apb(1'b1, htc_pkg::OFF_FBADDR, 32'h0003_0720);
    snap = swpos;
    apb(1'b1, htc_pkg::OFF_CTRL, 32'h1);
    wait_on(0, 1'b0, 4);
    wait_on(0, 1'b1, 12);
    apb(1'b0, htc_pkg::OFF_CAPT, 32'h0);
    chk("soft capture", snap, q);
    stop_move();
    lag <= 32'h0;
    apb(1'b1, htc_pkg::OFF_FBADDR, htc_pkg::FBADDR_RST);
    apb(1'b1, htc_pkg::OFF_TRIG, 32'h0000_000C);
    apb(1'b1, htc_pkg::OFF_CTRL, 32'h9);
    wait_on(1, 1'b1, 10);
    chk("hold", 32'h1, {31'h0, hold});
    idx <= 1'b1;
    repeat (2) @(posedge clk_sys);
    idx <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("index alone", 32'h1, {31'h0, srch});
    flg[0] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("switch alone", 32'h1, {31'h0, srch});
    snap = enc;
    idx <= 1'b1;
    wait_on(0, 1'b1, 10);
    idx <= 1'b0;
    apb(1'b0, htc_pkg::OFF_CAPT, 32'h0);
    chk("dual capture", snap, q);
    wait_on(2, 1'b1, 80000);
    chk("limits back", 32'h1, {31'h0, slim});
    chk("stop at home", snap + 32'h2, cmdpos);
    @(posedge clk_sys);
    chk("hold free", 32'h0, {31'h0, hold});
    apb(1'b0, htc_pkg::OFF_POS, 32'h0);
    chk("pos zero", 32'h0, q);
    flg[0] <= 1'b0;
    apb(1'b1, htc_pkg::OFF_JOGOFS, 32'h0000_0003);
    apb(1'b1, htc_pkg::OFF_TRIG, 32'h0000_0004);
    apb(1'b1, htc_pkg::OFF_CTRL, 32'h3);
    wait_on(1, 1'b1, 10);
    chk("jog keeps home", 32'h1, {31'h0, home});
    snap = enc;
    flg[0] <= 1'b1;
    wait_on(1, 1'b0, 10);
    apb(1'b0, htc_pkg::OFF_CAPT, 32'h0);
    chk("jog capture", snap, q);
    stop_move();
    apb(1'b1, htc_pkg::OFF_CTRL, 32'h1);
    wait_on(1, 1'b1, 10);
    apb(1'b1, htc_pkg::OFF_CTRL, 32'h4);
    wait_on(2, 1'b1, 10);
    chk("abort home", 32'h0, {31'h0, home});
    chk("abort limits", 32'h1, {31'h0, slim});
    final_report();
  end
endmodule

bind htc_top htc_monitor u_htc_monitor
(
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .HOME_COMPLETE(HOME_COMPLETE), .SEARCH_IN_PROGRESS(SEARCH_IN_PROGRESS),
  .VELOCITY_ZERO(VELOCITY_ZERO), .SOFT_LIMITS_ENABLED(SOFT_LIMITS_ENABLED),
  .PROGRAM_HOLD(PROGRAM_HOLD), .LIMIT_PROTECT_OFF(LIMIT_PROTECT_OFF)
);
